// File: stx_pkg.sv
package stx_pkg;

  // ----------------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------------
  localparam int TX_FIFO_DEPTH   = 4;   // Transmit FIFO bytes
  localparam int SCLK_HALF_NS    = 100; // Half period of generated clock
  localparam int CLOCK_NS        = 25;  // Period of clock
  localparam int SCLK_HALF_CYC   = (SCLK_HALF_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int IO_FRAME_BITS   = 8;   // Bits per clocked-mode frame

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int FCNF_FIFO_CONFIG_ENABLE_BIT    = 0;  // FIFO configuration enable
  localparam int FCNF_INHIBIT_BIT = 1;  // Stop after last word
  localparam int TFC_CMD_MSB      = 7;  // FIFO control command field
  localparam int TFC_CMD_LSB      = 6;
  localparam int TFC_LVL_MSB      = 1;  // Interrupt fill level field
  localparam int TFC_LVL_LSB      = 0;

  // ----------------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] TFC_CMD_CLEAR   = 2'h1;
  localparam logic [1:0] DUPLEX_NO_TXFF  = 2'h1;
  localparam logic [1:0] FILL_LVL_RESET  = 2'h0;
  localparam logic       BUF2_EMPTY_RST  = 1'h1;

  // Transmit state machine
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } stx_state_type;

  // Static configuration carried as one group
  typedef struct packed {
    logic       io_mode;          // 1: clocked interface, 0: UART
    logic       sclk_input;       // Clocked mode takes an external clock
    logic       double_buf;       // Second send buffer in use
    logic [4:0] fifo_config_reg;  // FIFO configuration field
    logic [1:0] duplex_select;    // Duplex select
    logic       seven_bit;        // 7-bit UART data, else 8-bit
    logic       parity_enable;    // Append parity in UART mode
    logic       parity_even;      // Even parity, else odd
    logic       cts_gate_enable;  // Gate frames with clear-to-send
  } stx_cfg_type;

endpackage : stx_pkg

// File: stx_fifo.sv
`timescale 1ns/1ps
module stx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = stx_pkg::TX_FIFO_DEPTH,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Control
  input  wire logic             clear,
  // Fill side
  input  wire logic             push_valid,
  output logic                  push_ready,
  input  wire logic [WIDTH-1:0] push_data,
  // Drain side
  output logic                  pop_valid,
  input  wire logic             pop_ready,
  output logic      [WIDTH-1:0] pop_data,
  output logic      [CW-1:0]    count
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  logic             push;
  logic             pop;

  // Handshake decode
  assign push_ready = (cnt_q != CW'(DEPTH));
  assign pop_valid  = (cnt_q != '0);
  assign push       = push_valid & push_ready;
  assign pop        = pop_valid & pop_ready;
  assign pop_data   = mem_q[rd_q];
  assign count      = cnt_q;

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= push_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (clear) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)  rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end

endmodule : stx_fifo

// File: stx_core.sv
// How it works
// - Clear-to-send gates frames only when its enable is set.
// - A raised clear-to-send lets the frame finish and holds the next.
// - While held, the interrupt and buffer writes still proceed.
// - A held UART frame starts on a falling bit-clock edge.
// - With double buffering, buffer two moves into the shift register.
// - Without FIFO, that move pulses interrupt and sets empty flag.
// - With FIFO, a queued byte refills buffer two and clears the flag.
// - External clock, no FIFO: empty buffer at next clock flags underrun.
// - External clock, FIFO: both moves happen in the same step.
// - Generated clock, no FIFO: clock stops when no word is left.
// - Generated clock, FIFO: clock stops when FIFO holds nothing.
// - Single buffering: writes load the shifter, interrupt at frame end.
// - Four-byte FIFO, enabled by config enable, duplex select and double buffering.
// - Control 01 in bits 7:6 clears FIFO; bits 1:0 set fill level.
// - FIFO interrupt when a pop leaves the programmed fill level.
// - Continuation inhibited, generated clock with FIFO: sequence ends after the last word.
// - One config bit chooses stop or continue after the last word.
// - Parity only in 7/8-bit UART, polarity from even select.
// - Sent parity kept in bit seven or ninth-bit field.
// - Received parity recomputed and compared; mismatch sets flag.
// - Overrun on unread buffer or full FIFO; clears when read.
// - Underrun only with double buffering and both stores empty.
`timescale 1ns/1ps
module stx_core #(
  parameter int FIFO_DEPTH = stx_pkg::TX_FIFO_DEPTH,
  parameter int SCLK_HALF  = stx_pkg::SCLK_HALF_CYC
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               reset_n,
  // Configuration
  input  wire stx_pkg::stx_cfg_type cfg,
  input  wire logic               transmit_enable_bit,
  // Core side writes and reads
  input  wire logic               data_write,
  input  wire logic [7:0]         write_data,
  output logic                    write_ready,
  input  wire logic               fifo_ctrl_write,
  input  wire logic [7:0]         tx_fifo_control,
  input  wire logic               flag_read,
  // Receive path events
  input  wire logic               rx_frame_done,
  input  wire logic [7:0]         rx_data,
  input  wire logic               rx_ninth_bit,
  input  wire logic               rx_buf_unread,
  input  wire logic               rx_fifo_enabled,
  input  wire logic               rx_fifo_full,
  // Line side
  input  wire logic               clear_to_send_input,
  input  wire logic               tx_bit_clock,
  input  wire logic               shift_clock_in,
  output logic                    txd,
  output logic                    shift_clock_out,
  output logic                    shift_clock_oe,
  // Status
  output logic                    tx_interrupt,
  output logic                    tx_fifo_irq,
  output logic                    tx_buf2_empty_flag,
  output logic                    parity_underrun_flag,
  output logic                    overrun_flag,
  output logic                    tx_bit_seven,
  output logic                    tx_ninth_bit,
  output logic                    tx_busy,
  output logic                    tx_run
);

  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int DW = (SCLK_HALF > 1) ? $clog2(SCLK_HALF) : 1;

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] last_q;

  // Two flops per pin, a third for edges
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 3'h7;
      sync_q <= 3'h7;
      last_q <= 3'h7;
    end else begin
      meta_q <= {shift_clock_in, tx_bit_clock, clear_to_send_input};
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  logic cts_high;
  logic bclk_fall;
  logic sclk_fall;
  assign cts_high  = sync_q[0];
  assign bclk_fall = last_q[1] & ~sync_q[1];
  assign sclk_fall = last_q[2] & ~sync_q[2];

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  logic fifo_en;
  logic wbuf;
  logic io_in;
  logic io_out;
  logic uart;
  logic inhibit;
  // FIFO needs config enable plus a duplex mode with transmit
  assign fifo_en = cfg.fifo_config_reg[stx_pkg::FCNF_FIFO_CONFIG_ENABLE_BIT] &
                   (cfg.duplex_select[1]) & cfg.double_buf;
  assign inhibit = cfg.fifo_config_reg[stx_pkg::FCNF_INHIBIT_BIT];
  assign wbuf    = cfg.double_buf;
  assign uart    = ~cfg.io_mode;
  assign io_in   = cfg.io_mode & cfg.sclk_input;
  assign io_out  = cfg.io_mode & ~cfg.sclk_input;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  stx_pkg::stx_state_type st_q;
  logic [10:0]   sr_q;
  logic [3:0]    cnt_q;
  logic [3:0]    nbits_q;
  logic          par_q;
  logic [7:0]    sh_word_q;
  logic          sh_pend_q;
  logic [7:0]    buf2_q;
  logic          buf2_full_q;
  logic          empty_q;
  logic          need_q;
  logic          seq_stop_q;
  logic          armed_q;
  logic [1:0]    fill_q;
  logic          sclk_q;
  logic [DW-1:0] div_q;
  logic          parity_underrun_flag_q;
  logic          overrun_flag_q;
  logic          tb7_q;
  logic          tb8_q;

  // FIFO wiring
  logic          ff_push_ready;
  logic          ff_valid;
  logic [7:0]    ff_data;
  logic [CW-1:0] ff_count;
  logic          ff_clear;
  assign ff_clear = fifo_ctrl_write &
    (tx_fifo_control[stx_pkg::TFC_CMD_MSB:stx_pkg::TFC_CMD_LSB] ==
     stx_pkg::TFC_CMD_CLEAR);

  // ----------------------------------------------------------------------
  // Buffer movement
  // ----------------------------------------------------------------------
  logic idle;
  logic sh_free;
  logic mv;
  logic ff_pop;
  logic wr_direct;
  logic wr_buf2;
  logic wr_fifo;
  assign idle      = (st_q == stx_pkg::ST_IDLE);
  assign sh_free   = ~sh_pend_q & idle;
  // Buffer two feeds the shifter even while clear-to-send holds
  assign mv        = wbuf & buf2_full_q & sh_free;
  // Queued byte refills buffer two in the same step as the move
  assign ff_pop    = fifo_en & ff_valid & (~buf2_full_q | mv);
  assign wr_direct = data_write & ~wbuf & sh_free;
  assign wr_fifo   = data_write & fifo_en;
  assign wr_buf2   = data_write & wbuf & ~fifo_en & ~buf2_full_q;
  assign write_ready = ~wbuf ? sh_free :
                       (fifo_en ? ff_push_ready : ~buf2_full_q);

  // ----------------------------------------------------------------------
  // Frame timing
  // ----------------------------------------------------------------------
  logic cts_ok;
  logic go;
  logic start_edge;
  logic tick;
  logic frame_start;
  logic frame_end;
  logic int_rise;
  logic div_wrap;
  // Input only matters when gating is enabled
  assign cts_ok = ~cfg.cts_gate_enable | ~cts_high;
  assign tx_run = transmit_enable_bit & ~seq_stop_q;
  assign go     = tx_run & cts_ok;
  // Held UART frame waits for a falling bit-clock edge
  assign start_edge = uart ? bclk_fall : (io_in ? sclk_fall : 1'b1);
  assign div_wrap   = (div_q == DW'(SCLK_HALF - 1));
  assign int_rise   = ~idle & div_wrap & ~sclk_q;
  assign tick  = uart ? bclk_fall : (io_in ? sclk_fall : int_rise);
  assign frame_start = idle & sh_pend_q & go & start_edge;
  assign frame_end   = ~idle & tick & (cnt_q == nbits_q - 4'h1);

  // Parity of the pending word with polarity applied
  logic par_next;
  assign par_next = (cfg.seven_bit ? ^sh_word_q[6:0] : ^sh_word_q)
                    ^ ~cfg.parity_even;

  // Frame image: start, data LSB first, optional parity, stop
  function automatic logic [10:0] build_frame(input logic [7:0] d,
                                              input logic sev,
                                              input logic pe,
                                              input logic p,
                                              input logic io);
    logic [10:0] f;
    f = 11'h7FF;
    if (io) begin
      f[7:0] = d;
    end else begin
      f[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (i < 7 || !sev) f[i+1] = d[i];
      end
      if (pe) f[sev ? 8 : 9] = p;
    end
    return f;
  endfunction : build_frame

  logic [3:0] nbits_next;
  assign nbits_next = cfg.io_mode ? 4'(stx_pkg::IO_FRAME_BITS) :
    (4'h9 - 4'(cfg.seven_bit) + 4'(cfg.parity_enable));

  // Shifter and state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q    <= stx_pkg::ST_IDLE;
      sr_q    <= 11'h7FF;
      cnt_q   <= 4'h0;
      nbits_q <= 4'h0;
      par_q   <= 1'b0;
    end else if (frame_start) begin
      st_q    <= stx_pkg::ST_SHIFT;
      sr_q    <= build_frame(sh_word_q, cfg.seven_bit,
                   cfg.parity_enable & uart, par_next, cfg.io_mode);
      cnt_q   <= 4'h0;
      nbits_q <= nbits_next;
      par_q   <= par_next;
    end else if (frame_end) begin
      st_q    <= stx_pkg::ST_IDLE;
      sr_q    <= 11'h7FF;
    end else if (!idle && tick) begin
      sr_q    <= {1'b1, sr_q[10:1]};
      cnt_q   <= cnt_q + 4'h1;
    end
  end

  // Generated shift clock runs only during a frame
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_q  <= '0;
      sclk_q <= 1'b0;
    end else if (idle || !io_out) begin
      div_q  <= '0;
      sclk_q <= 1'b0;
    end else begin
      div_q  <= div_wrap ? '0 : div_q + 1'b1;
      if (div_wrap) sclk_q <= ~sclk_q;
    end
  end

  // Send buffers, pending word and empty flag
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sh_word_q   <= 8'h00;
      sh_pend_q   <= 1'b0;
      buf2_q      <= 8'h00;
      buf2_full_q <= 1'b0;
      empty_q     <= stx_pkg::BUF2_EMPTY_RST;
    end else begin
      if (mv || wr_direct) begin
        sh_word_q <= mv ? buf2_q : write_data;
        sh_pend_q <= 1'b1;
      end else if (frame_start) begin
        sh_pend_q <= 1'b0;
      end
      if (ff_pop || wr_buf2) begin
        buf2_q      <= ff_pop ? ff_data : write_data;
        buf2_full_q <= 1'b1;
        empty_q     <= 1'b0;
      end else if (mv) begin
        buf2_full_q <= 1'b0;
        empty_q     <= 1'b1;
      end
    end
  end

  // Interrupts: on move when double buffered without FIFO, at frame end when single buffered
  assign tx_interrupt = (wbuf & mv & ~fifo_en) |
                        (~wbuf & frame_end);

  // FIFO control and fill-level interrupt
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
      fill_q  <= stx_pkg::FILL_LVL_RESET;
    end else if (fifo_ctrl_write) begin
      if (ff_clear) armed_q <= 1'b1;
      fill_q <= tx_fifo_control[stx_pkg::TFC_LVL_MSB:stx_pkg::TFC_LVL_LSB];
    end
  end
  assign tx_fifo_irq = ff_pop & armed_q &
                       (ff_count - CW'(1) == CW'(fill_q));

  // Underrun watch and sequence stop
  logic fifo_dry;
  assign fifo_dry = ~ff_valid | ~fifo_en;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      need_q     <= 1'b0;
      seq_stop_q <= 1'b0;
    end else begin
      if (frame_end) need_q <= io_in;
      else if (frame_start || sclk_fall) need_q <= 1'b0;
      if (!transmit_enable_bit) seq_stop_q <= 1'b0;
      else if (frame_end && io_out && fifo_en && inhibit && fifo_dry &&
               !buf2_full_q && !sh_pend_q) seq_stop_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Error flags, cleared by read; a set in the read cycle wins
  // ----------------------------------------------------------------------
  logic rx_par;
  logic rx_got;
  logic parity_underrun_flag_set;
  logic overrun_flag_set;
  assign rx_par = (cfg.seven_bit ? ^rx_data[6:0] : ^rx_data) ^
                  ~cfg.parity_even;
  assign rx_got = cfg.seven_bit ? rx_data[7] : rx_ninth_bit;
  assign parity_underrun_flag_set =
    (uart & cfg.parity_enable & rx_frame_done & (rx_par != rx_got)) |
    (io_in & wbuf & idle & need_q & sclk_fall & ~sh_pend_q &
     ~buf2_full_q & fifo_dry);
  assign overrun_flag_set = ~io_out & rx_frame_done &
    (rx_fifo_enabled ? rx_fifo_full : rx_buf_unread);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      parity_underrun_flag_q <= 1'b0;
      overrun_flag_q <= 1'b0;
    end else begin
      parity_underrun_flag_q <= parity_underrun_flag_set | (parity_underrun_flag_q & ~flag_read);
      overrun_flag_q <= overrun_flag_set | (overrun_flag_q & ~flag_read);
    end
  end

  // Sent parity kept after the frame
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tb7_q <= 1'b0;
      tb8_q <= 1'b0;
    end else if (frame_end && uart && cfg.parity_enable) begin
      if (cfg.seven_bit) tb7_q <= par_q;
      else tb8_q <= par_q;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit FIFO and outputs
  // ----------------------------------------------------------------------
  stx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock      (clock),
    .reset_n    (reset_n),
    .clear      (ff_clear),
    .push_valid (wr_fifo),
    .push_ready (ff_push_ready),
    .push_data  (write_data),
    .pop_valid  (ff_valid),
    .pop_ready  (fifo_en & (~buf2_full_q | mv)),
    .pop_data   (ff_data),
    .count      (ff_count)
  );

  assign txd                  = sr_q[0];
  assign shift_clock_out      = sclk_q;
  assign shift_clock_oe       = io_out;
  assign tx_buf2_empty_flag   = empty_q;
  assign parity_underrun_flag = parity_underrun_flag_q;
  assign overrun_flag         = overrun_flag_q;
  assign tx_bit_seven         = tb7_q;
  assign tx_ninth_bit         = tb8_q;
  assign tx_busy              = ~idle;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_CTS_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
    cfg.cts_gate_enable && cts_high |-> !frame_start)
    else $error("frame started while clear-to-send high");
  AST_CTS_FREE: assert property (@(posedge clock) disable iff (!reset_n)
    !cfg.cts_gate_enable && idle && sh_pend_q && tx_run && bclk_fall && uart
    |=> !idle)
    else $error("clear-to-send blocked with gating off");
  AST_START_EDGE: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(tx_busy) && uart |-> $past(bclk_fall))
    else $error("UART frame started off a falling bit-clock edge");
  AST_MOVE_FLAG: assert property (@(posedge clock) disable iff (!reset_n)
    mv && !fifo_en |-> tx_interrupt ##1 tx_buf2_empty_flag)
    else $error("move did not raise interrupt and empty flag");
  AST_SINGLE_IRQ: assert property (@(posedge clock) disable iff (!reset_n)
    tx_interrupt && !wbuf |-> tx_busy ##1 !tx_busy)
    else $error("single-buffer interrupt not at frame end");
  AST_OVERRUN: assert property (@(posedge clock) disable iff (!reset_n)
    rx_frame_done && rx_buf_unread && !rx_fifo_enabled && !io_out
    |=> overrun_flag)
    else $error("overrun not flagged");
  AST_NO_UNDERRUN: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(parity_underrun_flag) && cfg.io_mode |-> $past(wbuf))
    else $error("underrun flagged with double buffering off");
  AST_PARITY_KEEP: assert property (@(posedge clock) disable iff (!reset_n)
    frame_end && uart && cfg.parity_enable && cfg.seven_bit
    |=> tx_bit_seven == $past(par_q))
    else $error("sent parity not kept in bit seven");
  AST_SCLK_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
    !tx_busy ##1 !tx_busy |-> !shift_clock_out)
    else $error("shift clock runs with nothing to send");
  AST_FIFO_DEPTH: assert property (@(posedge clock) disable iff (!reset_n)
    ff_count <= CW'(FIFO_DEPTH))
    else $error("transmit FIFO above its depth");

endmodule : stx_core

// File: stx_peer.sv
`timescale 1ns/1ps
module stx_peer (
  // Commands from the bench
  input  wire logic hold,
  input  wire logic burst,
  // Line side
  output logic      clear_to_send_input,
  output logic      tx_bit_clock,
  output logic      shift_clock_in
);
  // Bit clock runs free, period 200 ns
  initial tx_bit_clock = 1'h1;
  always #100 tx_bit_clock = ~tx_bit_clock;

  // Raised level holds off the next frame
  assign clear_to_send_input = hold; // Hold-off level

  // External shift clock: sixteen pulses per burst, still and high between
  initial begin
    shift_clock_in = 1'h1;
    forever begin
      @(posedge burst);
      repeat (16) begin
        #100 shift_clock_in = 1'h0;
        #100 shift_clock_in = 1'h1;
      end
    end
  end
endmodule : stx_peer

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------
  // Bench signals
  // ----------------
  logic                 clock = 1'h0, reset_n = 1'h0;
  stx_pkg::stx_cfg_type cfg = '0;
  logic                 transmit_enable_bit = 1'h0, data_write = 1'h0;
  logic                 fifo_ctrl_write = 1'h0, flag_read = 1'h0;
  logic                 rx_frame_done = 1'h0, rx_ninth_bit = 1'h0;
  logic                 rx_buf_unread = 1'h0, rx_fifo_enabled = 1'h0;
  logic                 rx_fifo_full = 1'h0, hold = 1'h1, burst = 1'h0;
  logic [7:0]           write_data = 8'h00, tx_fifo_control = 8'h00;
  logic [7:0]           rx_data = 8'h00;
  logic                 clear_to_send_input, tx_bit_clock, shift_clock_in;
  logic                 txd, shift_clock_out, shift_clock_oe, write_ready;
  logic                 tx_interrupt, tx_fifo_irq, tx_buf2_empty_flag;
  logic                 parity_underrun_flag, overrun_flag, tx_bit_seven;
  logic                 tx_ninth_bit, tx_busy, tx_run;
  int                   err_count = 0, comparisons = 0;
  int                   sclk_rises = 0;
  wire  [3:0]           mon = {tx_run, tx_fifo_irq, tx_busy, tx_interrupt};

  // Clock at 40 MHz
  always #12.5 clock = ~clock;

  // Count generated shift clock rises
  always @(posedge shift_clock_out) sclk_rises++;

  // Design and far-side peer
  stx_core i_dut (
    .clock, .reset_n, .cfg, .transmit_enable_bit, .data_write,
    .write_data, .write_ready, .fifo_ctrl_write, .tx_fifo_control,
    .flag_read, .rx_frame_done, .rx_data, .rx_ninth_bit, .rx_buf_unread,
    .rx_fifo_enabled, .rx_fifo_full, .clear_to_send_input, .tx_bit_clock,
    .shift_clock_in, .txd, .shift_clock_out, .shift_clock_oe,
    .tx_interrupt, .tx_fifo_irq, .tx_buf2_empty_flag,
    .parity_underrun_flag, .overrun_flag, .tx_bit_seven, .tx_ninth_bit,
    .tx_busy, .tx_run
  );
  stx_peer i_peer (.hold, .burst, .clear_to_send_input, .tx_bit_clock,
    .shift_clock_in);

  // ----------------
  // Shared tasks
  // ----------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick

  task automatic check_bit(input string what, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask : check_bit

  task automatic wait_mon(input int k, input logic v, input int lim);
    for (int i = 0; i < lim && mon[k] !== v; i++) tick(1);
    if (mon[k] !== v) begin
      err_count++;
      $display("mismatch mon[%0d] expected %b seen %b", k, v, mon[k]);
    end
  endtask : wait_mon

  task automatic put(input logic [7:0] b);
    data_write = 1'h1;
    write_data = b;
    tick(1);
    data_write = 1'h0;
  endtask : put

  task automatic pulse_read();
    flag_read = 1'h1;
    tick(1);
    flag_read = 1'h0;
  endtask : pulse_read

  task automatic rx_event(input logic [7:0] d, input logic n, input logic u);
    {rx_data, rx_ninth_bit, rx_buf_unread, rx_frame_done} = {d, n, u, 1'h1};
    tick(1);
    rx_frame_done = 1'h0;
  endtask : rx_event

  task automatic tally_and_finish();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // ----------------
  // Scenarios
  // ----------------
  // Single buffer, gate off while pin high, even parity kept in ninth bit
  task automatic run_uart_single();
    logic [9:0] fr;
    fr = {1'h1, 8'hA7, 1'h0}; // Even parity, data, start
    cfg = '0;
    {cfg.parity_enable, cfg.parity_even} = 2'h3;
    transmit_enable_bit = 1'h1;
    put(8'hA7);
    wait_mon(1, 1'h1, 20);
    // Sample each bit in its middle, eight clocks per bit
    for (int k = 0; k < 10; k++) begin
      tick(k == 0 ? 4 : 8);
      check_bit("txd", fr[k], txd); // Frame bits
    end
    wait_mon(0, 1'h1, 8);
    check_bit("tx_interrupt", 1'h1, tx_interrupt); // Gate off
    tick(1);
    check_bit("tx_busy", 1'h0, tx_busy); // Frame over
    check_bit("txd", 1'h1, txd); // Stop level
    check_bit("tx_ninth_bit", 1'h1, tx_ninth_bit); // Parity
  endtask : run_uart_single

  // Double buffer held by clear-to-send, then released
  task automatic run_cts_hold();
    cfg = '0;
    {cfg.double_buf, cfg.cts_gate_enable} = 2'h3;
    {cfg.seven_bit, cfg.parity_enable} = 2'h3; // Odd parity, 7 bits
    put(8'h3C);
    check_bit("tx_interrupt", 1'h1, tx_interrupt); // Move
    tick(1);
    check_bit("tx_buf2_empty_flag", 1'h1, tx_buf2_empty_flag);
    tick(60);
    check_bit("tx_busy", 1'h0, tx_busy); // Held off
    hold = 1'h0;
    wait_mon(1, 1'h1, 14);
    check_bit("tx_busy", 1'h1, tx_busy); // Start on bit tick
    wait_mon(1, 1'h0, 200);
    check_bit("tx_bit_seven", 1'h1, tx_bit_seven); // Odd parity
    hold = 1'h1;
  endtask : run_cts_hold

  // Parity mismatch and overrun, cleared by read
  task automatic run_flags();
    cfg = '0;
    {cfg.parity_enable, cfg.parity_even} = 2'h3;
    rx_event(8'h01, 1'h0, 1'h1);
    check_bit("parity_underrun_flag", 1'h1, parity_underrun_flag);
    check_bit("overrun_flag", 1'h1, overrun_flag); // Unread
    pulse_read();
    check_bit("parity_underrun_flag", 1'h0, parity_underrun_flag);
    check_bit("overrun_flag", 1'h0, overrun_flag); // Read clears
    rx_event(8'h01, 1'h1, 1'h0);
    check_bit("parity_underrun_flag", 1'h0, parity_underrun_flag);
  endtask : run_flags

  // External clock, double buffer, no refill: underrun
  task automatic run_underrun();
    cfg = '0;
    {cfg.io_mode, cfg.sclk_input, cfg.double_buf} = 3'h7;
    put(8'h55);
    check_bit("write_ready", 1'h0, write_ready); // Buffer two full
    check_bit("tx_buf2_empty_flag", 1'h0, tx_buf2_empty_flag);
    tick(1);
    check_bit("write_ready", 1'h1, write_ready); // Moved on
    burst = 1'h1;
    tick(140);
    burst = 1'h0;
    check_bit("parity_underrun_flag", 1'h1, parity_underrun_flag);
    pulse_read();
  endtask : run_underrun

  // Generated clock, four FIFO bytes, continuation inhibited
  task automatic run_fifo_stop();
    cfg = '0;
    {cfg.io_mode, cfg.double_buf, cfg.duplex_select} = 4'hF;
    cfg.fifo_config_reg = 5'h0B;
    transmit_enable_bit = 1'h0;
    {tx_fifo_control, fifo_ctrl_write} = {8'h40, 1'h1};
    tick(1);
    fifo_ctrl_write = 1'h0;
    for (int i = 0; i < 4; i++) begin
      put(8'h10 | 8'(i));
      tick(1);
    end
    transmit_enable_bit = 1'h1;
    wait_mon(2, 1'h1, 600);
    check_bit("tx_fifo_irq", 1'h1, tx_fifo_irq); // Level 0
    wait_mon(3, 1'h0, 600);
    check_bit("tx_run", 1'h0, tx_run); // Stopped
    tick(20);
    check_bit("tx_busy", 1'h0, tx_busy); // Clock stops
    check_bit("shift_clock_out", 1'h0, shift_clock_out); // Still
    check_bit("shift_clock_oe", 1'h1, shift_clock_oe); // Driven
    // Only this scenario generates the shift clock: four frames
    check_bit("sclk_rises_is_32", 1'h1,
              sclk_rises == 4 * stx_pkg::IO_FRAME_BITS);
  endtask : run_fifo_stop

  // Main sequence
  initial begin
    tick(2);
    reset_n = 1'h1;
    tick(4);
    run_uart_single();
    run_cts_hold();
    run_flags();
    run_underrun();
    run_fifo_stop();
    tally_and_finish();
  end

  // Watchdog
  initial begin
    #125000;
    err_count++;
    tally_and_finish();
  end
endmodule : testbench
